//--- rtl/cs2_defs.svh
`ifndef CS2_DEFS_SVH
`define CS2_DEFS_SVH
// Register addresses on the special function register port
`define CS2_ADDR_SER_CTRL 8'h98
`define CS2_ADDR_SER_BUF 8'h99
`define CS2_ADDR_CNT_CTRL 8'hC8
`define CS2_ADDR_RLD_LO 8'hCA
`define CS2_ADDR_RLD_HI 8'hCB
`define CS2_ADDR_CNT_LO 8'hCC
`define CS2_ADDR_CNT_HI 8'hCD
// Counter control bit positions
`define CS2_B_OVF 7
`define CS2_B_EXT 6
`define CS2_B_RXCLK 5
`define CS2_B_TXCLK 4
`define CS2_B_EXEN 3
`define CS2_B_RUN 2
`define CS2_B_CSRC 1
`define CS2_B_CAPSEL 0
// Serial control bit positions
`define CS2_B_MODE_HI 7
`define CS2_B_MODE_LO 6
`define CS2_B_MP 5
`define CS2_B_RXEN 4
`define CS2_B_TX9 3
`define CS2_B_RX9 2
`define CS2_B_TXDONE 1
`define CS2_B_RXDONE 0
// Reset values and constants
`define CS2_RST_BYTE 8'h00
`define CS2_RST_WORD 16'h0000
`define CS2_CNT_MAX 16'hFFFF
`define CS2_ONE_WORD 16'h0001
`define CS2_DIV_W 5
`define CS2_DIV_RST 5'h00
`define CS2_DIV_ONE 5'h01
`define CS2_DIV_SHIFT 5'h01
`define CS2_DIV_SLOW 5'h1F
`define CS2_DIV_FAST 5'h0F
`endif

//--- rtl/cs2_pkg.sv
package cs2_pkg;
  // Counter operating mode, one-hot
  typedef enum logic [3:0] {
    CS2_OFF = 4'b0001,
    CS2_AUTO = 4'b0010,
    CS2_CAPT = 4'b0100,
    CS2_BAUD = 4'b1000
  } cs2_tmode_t;
  // Serial framing mode
  typedef enum logic [1:0] {
    CS2_SM_SHIFT = 2'h0,
    CS2_SM_UART8 = 2'h1,
    CS2_SM_FIX9 = 2'h2,
    CS2_SM_VAR9 = 2'h3
  } cs2_smode_t;
  // One serial word: eight data bits and the ninth (or stop) bit
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } cs2_word_t;
endpackage

//--- rtl/cs2_top.sv
`timescale 1ns/100ps
`include "cs2_defs.svh"
module cs2_top import cs2_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata_r,
  input wire logic trigger_input,
  input wire logic count_input_pin,
  input wire logic other_timer_ovf,
  input wire logic fixed_rate_fast,
  input wire logic rx_frame_valid,
  input wire cs2_word_t rx_frame,
  input wire logic tx_complete,
  output logic tx_load_r,
  output cs2_word_t tx_word_r,
  output cs2_smode_t serial_mode_r,
  output logic rx_enable_r,
  output logic rx_baud_tick_r,
  output logic tx_baud_tick_r,
  output logic counter_irq_r,
  output logic serial_irq_r
);
  // Byte-split registers assume exactly two bytes
  if (CNT_W != 16) begin : g_bad_width
    $error("cs2_top: CNT_W must be 16");
  end

  logic [7:0] ctl_r, ctl_nxt, serial_control_r, serial_control_nxt, rxbuf_r, rxbuf_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt, rld_r, rld_nxt;
  logic [1:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic [1:0] pin_raw, pin_fall;
  logic [`CS2_DIV_W-1:0] div_r, div_nxt;

  assign pin_raw = {count_input_pin, trigger_input};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_r[i] <= 1'b1;
        pin_s2_r[i] <= 1'b1;
        pin_d_r[i] <= 1'b1;
      end else begin
        pin_s1_r[i] <= pin_raw[i];
        pin_s2_r[i] <= pin_s1_r[i];
        pin_d_r[i] <= pin_s2_r[i];
      end
    end
    assign pin_fall[i] = pin_d_r[i] & ~pin_s2_r[i];
  end

  // Register port decode
  wire wr_ctl = sfr_wr && (sfr_addr == `CS2_ADDR_CNT_CTRL);
  wire wr_rlo = sfr_wr && (sfr_addr == `CS2_ADDR_RLD_LO);
  wire wr_rhi = sfr_wr && (sfr_addr == `CS2_ADDR_RLD_HI);
  wire wr_clo = sfr_wr && (sfr_addr == `CS2_ADDR_CNT_LO);
  wire wr_chi = sfr_wr && (sfr_addr == `CS2_ADDR_CNT_HI);
  wire wr_serial_control = sfr_wr && (sfr_addr == `CS2_ADDR_SER_CTRL);
  // write side of the buffer goes to transmit only
  wire wr_serial_buffer = sfr_wr && (sfr_addr == `CS2_ADDR_SER_BUF);
  wire cnt_wr = wr_clo | wr_chi;

  // serial clock select overrides capture select
  wire run = ctl_r[`CS2_B_RUN];
  wire baud_sel = ctl_r[`CS2_B_RXCLK] | ctl_r[`CS2_B_TXCLK];
  cs2_tmode_t tmode;
  assign tmode = !run ? CS2_OFF : baud_sel ? CS2_BAUD :
                 ctl_r[`CS2_B_CAPSEL] ? CS2_CAPT : CS2_AUTO;

  // one step per clock or per pin edge
  wire tick = run && (ctl_r[`CS2_B_CSRC] ? pin_fall[1] : 1'b1);
  wire rollover = tick && (cnt_r == `CS2_CNT_MAX);
  wire trig_ev = run && ctl_r[`CS2_B_EXEN] && pin_fall[0];
  wire do_reload = (rollover && (tmode == CS2_AUTO || tmode == CS2_BAUD)) ||
                   (trig_ev && tmode == CS2_AUTO);
  wire do_capture = trig_ev && (tmode == CS2_CAPT);
  // overflow flag in capture and autoreload
  wire ovf_set = rollover && (tmode != CS2_BAUD);
  // event flag on every enabled trigger edge, in any running mode, baud mode included
  wire ext_set = trig_ev;

  // Counter next value; software writes win over counting to keep loads exact
  always_comb begin
    cnt_nxt = cnt_r;
    if (do_reload) begin
      cnt_nxt = rld_r;
    end else if (tick) begin
      cnt_nxt = cnt_r + `CS2_ONE_WORD;
    end
    if (wr_clo) begin
      cnt_nxt[7:0] = sfr_wdata;
    end
    if (wr_chi) begin
      cnt_nxt[15:8] = sfr_wdata;
    end
  end

  // Reload/capture register; a capture beats a write in the same cycle
  always_comb begin
    rld_nxt = rld_r;
    if (wr_rlo) begin
      rld_nxt[7:0] = sfr_wdata;
    end
    if (wr_rhi) begin
      rld_nxt[15:8] = sfr_wdata;
    end
    if (do_capture) begin
      rld_nxt = cnt_r;
    end
  end

  // sticky flags, hardware set wins over a clearing write
  always_comb begin
    ctl_nxt = wr_ctl ? sfr_wdata : ctl_r;
    ctl_nxt[`CS2_B_OVF] = ovf_set | ctl_nxt[`CS2_B_OVF];
    ctl_nxt[`CS2_B_EXT] = ext_set | ctl_nxt[`CS2_B_EXT];
  end

  // serial mode from the two mode bits
  cs2_smode_t smode;
  assign smode = cs2_smode_t'({serial_control_r[`CS2_B_MODE_HI], serial_control_r[`CS2_B_MODE_LO]});
  wire var_rate = (smode == CS2_SM_UART8) || (smode == CS2_SM_VAR9);
  wire mp_on = serial_control_r[`CS2_B_MP] && (smode != CS2_SM_SHIFT);
  wire rx_accept = rx_frame_valid && (!mp_on || rx_frame.ninth);

  // newer byte overwrites an unread one
  assign rxbuf_nxt = rx_accept ? rx_frame.data : rxbuf_r;
  always_comb begin
    serial_control_nxt = wr_serial_control ? sfr_wdata : serial_control_r;
    if (rx_accept) begin
      serial_control_nxt[`CS2_B_RX9] = rx_frame.ninth;
    end
    serial_control_nxt[`CS2_B_RXDONE] = rx_accept | serial_control_nxt[`CS2_B_RXDONE];
    serial_control_nxt[`CS2_B_TXDONE] = tx_complete | serial_control_nxt[`CS2_B_TXDONE];
  end

  // Fixed-rate divider for shift mode and 9-bit fixed mode
  wire [`CS2_DIV_W-1:0] div_top = (smode == CS2_SM_SHIFT) ? `CS2_DIV_SHIFT :
                                  fixed_rate_fast ? `CS2_DIV_FAST : `CS2_DIV_SLOW;
  wire div_tick = (div_r >= div_top);
  assign div_nxt = div_tick ? `CS2_DIV_RST : div_r + `CS2_DIV_ONE;
  // per-direction source of the variable rate
  wire rx_tick_nxt = var_rate ? (ctl_r[`CS2_B_RXCLK] ? rollover : other_timer_ovf) : div_tick;
  wire tx_tick_nxt = var_rate ? (ctl_r[`CS2_B_TXCLK] ? rollover : other_timer_ovf) : div_tick;

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux = (sfr_addr == `CS2_ADDR_CNT_CTRL) ? ctl_r :
                      (sfr_addr == `CS2_ADDR_RLD_LO) ? rld_r[7:0] :
                      (sfr_addr == `CS2_ADDR_RLD_HI) ? rld_r[15:8] :
                      (sfr_addr == `CS2_ADDR_CNT_LO) ? cnt_r[7:0] :
                      (sfr_addr == `CS2_ADDR_CNT_HI) ? cnt_r[15:8] :
                      (sfr_addr == `CS2_ADDR_SER_CTRL) ? serial_control_r :
                      (sfr_addr == `CS2_ADDR_SER_BUF) ? rxbuf_r : `CS2_RST_BYTE;

  // State registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= `CS2_RST_BYTE;
      serial_control_r <= `CS2_RST_BYTE;
      rxbuf_r <= `CS2_RST_BYTE;
      cnt_r <= `CS2_RST_WORD;
      rld_r <= `CS2_RST_WORD;
      div_r <= `CS2_DIV_RST;
    end else begin
      ctl_r <= ctl_nxt;
      serial_control_r <= serial_control_nxt;
      rxbuf_r <= rxbuf_nxt;
      cnt_r <= cnt_nxt;
      rld_r <= rld_nxt;
      div_r <= div_nxt;
    end
  end

  // Registered outputs; interrupt lines follow the flags one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata_r <= `CS2_RST_BYTE;
      tx_load_r <= 1'b0;
      tx_word_r <= '0;
      serial_mode_r <= CS2_SM_SHIFT;
      rx_enable_r <= 1'b0;
      rx_baud_tick_r <= 1'b0;
      tx_baud_tick_r <= 1'b0;
      counter_irq_r <= 1'b0;
      serial_irq_r <= 1'b0;
    end else begin
      sfr_rdata_r <= sfr_rd ? rd_mux : sfr_rdata_r;
      tx_load_r <= wr_serial_buffer;
      tx_word_r <= wr_serial_buffer ? {sfr_wdata, serial_control_r[`CS2_B_TX9]} : tx_word_r;
      serial_mode_r <= smode;
      rx_enable_r <= serial_control_r[`CS2_B_RXEN];
      rx_baud_tick_r <= rx_tick_nxt;
      tx_baud_tick_r <= tx_tick_nxt;
      counter_irq_r <= ctl_r[`CS2_B_OVF] | ctl_r[`CS2_B_EXT];
      serial_irq_r <= serial_control_r[`CS2_B_RXDONE] | serial_control_r[`CS2_B_TXDONE];
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_off_holds;
    !run && !cnt_wr |=> $stable(cnt_r);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("count moved while off");
  property p_auto_roll;
    rollover && tmode == CS2_AUTO && !cnt_wr |=> ctl_r[`CS2_B_OVF] && cnt_r == $past(rld_r);
  endproperty
  a_auto_roll: assert property (p_auto_roll) else $error("rollover reload bad");
  property p_trig_reload;
    trig_ev && tmode == CS2_AUTO && !cnt_wr |=> cnt_r == $past(rld_r) && ctl_r[`CS2_B_EXT];
  endproperty
  a_trig_reload: assert property (p_trig_reload) else $error("trigger reload bad");
  property p_capture;
    do_capture |=> rld_r == $past(cnt_r) && ctl_r[`CS2_B_EXT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture bad");
  property p_baud_noflag;
    tmode == CS2_BAUD && !ctl_r[`CS2_B_OVF] && !wr_ctl |=> !ctl_r[`CS2_B_OVF];
  endproperty
  a_baud_noflag: assert property (p_baud_noflag) else $error("overflow flag in baud mode");
  property p_irq;
    ctl_r[`CS2_B_EXT] |=> counter_irq_r;
  endproperty
  a_irq: assert property (p_irq) else $error("event flag gave no interrupt");
  property p_sticky;
    ctl_r[`CS2_B_OVF] && !wr_ctl |=> ctl_r[`CS2_B_OVF];
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");
  property p_step;
    tick && !rollover && !cnt_wr && !do_reload |=> cnt_r == $past(cnt_r) + `CS2_ONE_WORD;
  endproperty
  a_step: assert property (p_step) else $error("count step wrong");
  property p_overwrite;
    rx_accept |=> rxbuf_r == $past(rx_frame.data) && serial_control_r[`CS2_B_RXDONE];
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("receive byte not stored");
  property p_mp_filter;
    rx_frame_valid && mp_on && !rx_frame.ninth && !serial_control_r[`CS2_B_RXDONE] && !wr_serial_control
      |=> !serial_control_r[`CS2_B_RXDONE];
  endproperty
  a_mp_filter: assert property (p_mp_filter) else $error("filtered frame flagged");
  property p_tx_load;
    wr_serial_buffer |=> tx_load_r && tx_word_r.data == $past(sfr_wdata) ##1 (!tx_load_r || $past(wr_serial_buffer));
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("transmit load bad");
  property p_baud_tick;
    var_rate && ctl_r[`CS2_B_RXCLK] && rollover |=> rx_baud_tick_r;
  endproperty
  a_baud_tick: assert property (p_baud_tick) else $error("no receive baud tick");
  c_capture: cover property (do_capture);
  c_trig_reload: cover property (trig_ev && tmode == CS2_AUTO);
  c_overwrite: cover property (rx_accept && serial_control_r[`CS2_B_RXDONE]);
  c_baud: cover property (tmode == CS2_BAUD && rollover);
endmodule

//--- tb/cs2_far_end.sv
`timescale 1ns/100ps
// Far side: serial shifters and the two external pins
module cs2_far_end import cs2_pkg::*; (
  input wire logic clk_sys,
  input wire logic tx_load_r,
  output logic tx_complete,
  output logic rx_frame_valid,
  output cs2_word_t rx_frame,
  output logic trigger_input,
  output logic count_input_pin
);
  int tx_wait = 0;
  // Pins idle high as if pulled up, so no false edge at start
  initial begin
    tx_complete = 1'b0;
    rx_frame_valid = 1'b0;
    rx_frame = 9'h000;
    trigger_input = 1'b1;
    count_input_pin = 1'b1;
  end
  // transmitter finishes on its own, whatever the receiver does
  always @(posedge clk_sys) begin
    tx_complete <= #1 (tx_wait == 1);
    if (tx_load_r)
      tx_wait <= 8;
    else if (tx_wait > 0)
      tx_wait <= tx_wait - 1;
  end
  // Frame valid one cycle; afterwards the lines show the inverse, not stale data
  task automatic send_frame(input cs2_word_t w);
    @(posedge clk_sys);
    #1;
    rx_frame_valid = 1'b1;
    rx_frame = w;
    @(posedge clk_sys);
    #1;
    rx_frame_valid = 1'b0;
    rx_frame = ~w;
  endtask
  // pulses stay four clocks low and high, above the two-clock minimum
  task automatic pin_pulse(input bit trig);
    repeat (4) @(posedge clk_sys);
    #1;
    if (trig)
      trigger_input = 1'b0;
    else
      count_input_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    trigger_input = 1'b1;
    count_input_pin = 1'b1;
  endtask
endmodule

//--- tb/cs2_top_test.sv
`timescale 1ns/100ps
`include "cs2_defs.svh"
module cs2_top_test import cs2_pkg::*; ;
  logic clk_sys, rst_n, sfr_wr, sfr_rd, other_timer_ovf, fixed_rate_fast;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, v, d;
  logic tx_complete, rx_frame_valid, trigger_input, count_input_pin, tx_load_r;
  logic rx_enable_r, rx_baud_tick_r, tx_baud_tick_r, counter_irq_r, serial_irq_r;
  cs2_word_t rx_frame, tx_word_r;
  cs2_smode_t serial_mode_r;
  int fails = 0;
  int num_checks = 0;
  int n;
  int k;
  cs2_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
    .trigger_input(trigger_input), .count_input_pin(count_input_pin),
    .other_timer_ovf(other_timer_ovf), .fixed_rate_fast(fixed_rate_fast),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame), .tx_complete(tx_complete),
    .tx_load_r(tx_load_r), .tx_word_r(tx_word_r), .serial_mode_r(serial_mode_r),
    .rx_enable_r(rx_enable_r), .rx_baud_tick_r(rx_baud_tick_r),
    .tx_baud_tick_r(tx_baud_tick_r), .counter_irq_r(counter_irq_r),
    .serial_irq_r(serial_irq_r));
  cs2_far_end far (.clk_sys(clk_sys), .tx_load_r(tx_load_r), .tx_complete(tx_complete),
    .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .trigger_input(trigger_input), .count_input_pin(count_input_pin));
  // Clock, 20 ns period
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register port: strobes last one cycle, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_rd = 1'b0;
    @(posedge clk_sys);
    #1;
    r = sfr_rdata_r;
  endtask
  task automatic chkr(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd(a, r);
    chk(r, exp);
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // A hang counts as a mismatch
  initial begin
    #1000000;
    fails++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    other_timer_ovf = 1'b0;
    fixed_rate_fast = 1'b1;
    void'($urandom(32'h8244));
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    // Reset values, unmapped 9A reads zero
    foreach (v[i]) chkr(8'h98 + 8'(i < 2 ? i : i + 46), 8'h00);
    chkr(8'h9A, 8'h00);
    $display("Reset test done");
    // Rollover from FFFE reloads 1234 and sets the overflow flag
    wr(8'hCA, 8'h34); wr(8'hCB, 8'h12); wr(8'hCC, 8'hFE); wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h04);
    repeat (6) @(posedge clk_sys);
    chkr(8'hC8, 8'h84);
    chkr(8'hCD, 8'h12);
    wr(8'hC8, 8'h00);
    chkr(8'hC8, 8'h00);
    rd(8'hCC, v);
    chkr(8'hCC, v);
    // Trigger edge in autoreload mode forces the reload early
    wr(8'hCB, 8'h9A); wr(8'hCD, 8'h00); wr(8'hC8, 8'h0C);
    far.pin_pulse(1'b1);
    chkr(8'hC8, 8'h4C);
    chkr(8'hCD, 8'h9A);
    // Capture copies the count; high byte 56 differs from the old 9A
    wr(8'hC8, 8'h00); wr(8'hCD, 8'h56); wr(8'hC8, 8'h0D);
    far.pin_pulse(1'b1);
    chkr(8'hC8, 8'h4D);
    chk(counter_irq_r, 1'b1);
    chkr(8'hCB, 8'h56);
    // Capture rollover goes to zero, not to the reload value
    wr(8'hC8, 8'h00); wr(8'hCC, 8'hFE); wr(8'hCD, 8'hFF); wr(8'hC8, 8'h05);
    repeat (6) @(posedge clk_sys);
    chkr(8'hC8, 8'h85);
    chkr(8'hCD, 8'h00);
    $display("Counter mode test done");
    // Baud mode with capture select set: reload on rollover, no overflow flag
    wr(8'hC8, 8'h00); wr(8'h98, 8'h40); wr(8'hCA, 8'hF0); wr(8'hCB, 8'hFF);
    wr(8'hCC, 8'hF0); wr(8'hCD, 8'hFF); wr(8'hC8, 8'h35);
    for (n = 0; n < 100 && tx_baud_tick_r !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(n < 100, 1'b1);
    repeat (40) @(posedge clk_sys);
    chkr(8'hC8, 8'h35);
    chkr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h3D);
    far.pin_pulse(1'b1);
    chkr(8'hC8, 8'h7D);
    chk(counter_irq_r, 1'b1);
    // Counter function counts only count pin edges
    n = 1 + $urandom % 7;
    wr(8'hC8, 8'h00); wr(8'hCC, 8'h00); wr(8'hCD, 8'h00); wr(8'hC8, 8'h06);
    repeat (n) far.pin_pulse(1'b0);
    wr(8'hC8, 8'h00);
    chkr(8'hCC, 8'(n));
    $display("Baud and count pin test done");
    // Every serial mode; buffer write goes to the transmit side
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      wr(8'h98, {m[1:0], 6'h18});
      wr(8'h99, d);
      chk({tx_load_r, tx_word_r}, {1'b1, d, 1'b1});
      chk(serial_mode_r, m[1:0]);
    end
    repeat (12) @(posedge clk_sys);
    chkr(8'h98, 8'hDA);
    // Multiprocessor filter per mode, then two frames one idle cycle apart
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      wr(8'h98, {m[1:0], 6'h30});
      far.send_frame({d, 1'b0});
      repeat (2) @(posedge clk_sys);
      chkr(8'h98, {m[1:0], 5'h18, m == 0});
      far.send_frame({d, 1'b1});
      far.send_frame({~d, 1'b1});
      repeat (2) @(posedge clk_sys);
      chkr(8'h99, ~d);
      chkr(8'h98, {m[1:0], 6'h35});
    end
    chk(serial_irq_r, 1'b1);
    // Select bits clear: the other timer's overflow clocks both directions
    other_timer_ovf = 1'b1;
    @(posedge clk_sys);
    #1;
    other_timer_ovf = 1'b0;
    chk({rx_baud_tick_r, tx_baud_tick_r}, 2'b11);
    @(posedge clk_sys);
    #1;
    chk({rx_baud_tick_r, tx_baud_tick_r}, 2'b00);
    // Fixed rates: shift mode every 2 clocks, 9-bit fixed every 16 or 32
    for (int m = 0; m < 3; m++) begin
      fixed_rate_fast = (m == 1);
      wr(8'h98, {(m == 0) ? 2'h0 : 2'h2, 6'h00});
      k = 0;
      repeat (64) begin
        @(posedge clk_sys);
        #1;
        k += rx_baud_tick_r;
      end
      chk(16'(k), 16'((m == 0) ? 32 : (m == 1) ? 4 : 2));
      chk(rx_enable_r, 1'b0);
    end
    $display("Serial test done");
    finish_test();
  end
endmodule
